// ===== hw/hsq_homing.sv
/*
 * homing sequencer for methods 11 to 14, 17 and 18: step-table driven search of
 * home switch, limit switches and encoder index, giving direction and speed.
 * assumes the motion loop follows moveFwd/speedCmd; switch inputs active high.
 */
`timescale 1ns/100ps
`default_nettype none
`include "hsq_params.svh"

// What this block does
// - m11 off: fast rev rise, stop, fwd
// - m11 on: slow fwd fall, then fwd index
// - m11 rev limit: fast fwd, stop, rev
// - m12 off: fast rev, fwd fall, rev rise, rev index
// - m12 on: fwd fall, rev rise, rev index
// - m12 rev limit: fast fwd fall, rev, rev index
// - m13 off: fast rev fall, fwd rise, fwd index
// - m13 on: same sequence as switch off
// - m13 rev limit: fwd rise, rev fall, fwd rise
// - m14 any: rev fall, fwd rise, rev fall, index
// - m14 rev limit: fwd rise, rev fall, rev index
// - codes 15, 16 reserved, no sequence run
// - m17 off: fast rev to limit, slow fwd off
// - m17 on limit: slow fwd to limit release
// - m18 off: fast fwd to limit, slow rev off
// - m18 on limit: slow rev to limit release
module hsq_homing #(
    parameter int SPEED_W           = `HSQ_SPEED_W,
    parameter int DECEL_CYCLES      = `HSQ_DECEL_CYC,
    parameter int DEBOUNCE_CYCLES   = `HSQ_DEBOUNCE_CYC,
    parameter int INDEX_FILT_CYCLES = `HSQ_INDEX_FILT_CYC
) (
    input  wire logic                     clk,
    input  wire logic                     nrst,
    input  wire logic                     startHoming,
    input  wire logic [`HSQ_METHOD_W-1:0] methodSel,
    input  wire logic [SPEED_W-1:0]       highSpeed,
    input  wire logic [SPEED_W-1:0]       lowSpeed,
    input  wire logic                     homeSwitch,
    input  wire logic                     fwdLimit,
    input  wire logic                     revLimit,
    input  wire logic                     indexPulse,
    output logic                          moveFwd_q,
    output logic      [SPEED_W-1:0]       speedCmd_q,
    output logic                          homingBusy_q,
    output logic                          homingDone_q,
    output logic                          methodError_q
);

    localparam int DW = $clog2(DECEL_CYCLES + 1);

    localparam hsq_pkg::hsq_dir_type  FWD   = hsq_pkg::DIR_FWD;
    localparam hsq_pkg::hsq_dir_type  REV   = hsq_pkg::DIR_REV;
    localparam hsq_pkg::hsq_spd_type  HI    = hsq_pkg::SPD_HIGH;
    localparam hsq_pkg::hsq_spd_type  LO    = hsq_pkg::SPD_LOW;
    localparam hsq_pkg::hsq_sig_type  HOME  = hsq_pkg::SIG_HOME;
    localparam hsq_pkg::hsq_sig_type  RLIM  = hsq_pkg::SIG_REVLIM;
    localparam hsq_pkg::hsq_sig_type  FLIM  = hsq_pkg::SIG_FWDLIM;
    localparam hsq_pkg::hsq_sig_type  INDEX = hsq_pkg::SIG_INDEX;
    localparam hsq_pkg::hsq_edge_type RISE  = hsq_pkg::EDGE_RISE;
    localparam hsq_pkg::hsq_edge_type FALL  = hsq_pkg::EDGE_FALL;

    logic                      rstMetaN_q;
    logic                      rstN_q;
    logic [2:0]                swLvl;
    logic                      idxLvl;
    logic [3:0]                lvl;
    logic [3:0]                prevLvl_q;
    logic [3:0]                rise;
    logic [3:0]                fall;
    hsq_pkg::hsq_state_type    state_q;
    hsq_pkg::hsq_state_type    state_d;
    hsq_pkg::hsq_prog_type     prog_q;
    hsq_pkg::hsq_prog_type     prog_d;
    logic [`HSQ_STEP_W-1:0]    idx_q;
    logic [`HSQ_STEP_W-1:0]    idx_d;
    logic [DW-1:0]             cnt_q;
    logic [DW-1:0]             cnt_d;
    hsq_pkg::hsq_step_type     curStep;
    hsq_pkg::hsq_step_type     nxtStep;
    logic                      startTake;
    logic                      hit;
    logic                      fallback;
    logic                      moveFwd_d;
    logic [SPEED_W-1:0]        speedCmd_d;

    // async assert, sync release
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rstMetaN_q <= 1'b0;
            rstN_q     <= 1'b0;
        end
        else
        begin
            rstMetaN_q <= 1'b1;
            rstN_q     <= rstMetaN_q;
        end
    end

    // switches bounce mechanically; the index is clean but narrow, so a short filter
    hsq_debounce #(
        .WIDTH  (3),
        .CYCLES (DEBOUNCE_CYCLES)
    ) swDeb (
        .clk   (clk),
        .rstN  (rstN_q),
        .raw   ({fwdLimit, revLimit, homeSwitch}),
        .level (swLvl)
    );

    hsq_debounce #(
        .WIDTH  (1),
        .CYCLES (INDEX_FILT_CYCLES)
    ) idxDeb (
        .clk   (clk),
        .rstN  (rstN_q),
        .raw   (indexPulse),
        .level (idxLvl)
    );

    assign lvl  = {idxLvl, swLvl[2], swLvl[1], swLvl[0]};
    assign rise = lvl & ~prevLvl_q;
    assign fall = ~lvl & prevLvl_q;

    function automatic hsq_pkg::hsq_step_type srch(
        input hsq_pkg::hsq_dir_type  d,
        input hsq_pkg::hsq_spd_type  s,
        input hsq_pkg::hsq_sig_type  g,
        input hsq_pkg::hsq_edge_type e
    );
        srch = '{kind: hsq_pkg::K_SEARCH, dir: d, spd: s, sig: g, edg: e};
    endfunction

    function automatic hsq_pkg::hsq_step_type fixed(input hsq_pkg::hsq_kind_type k);
        fixed = '{kind: k, dir: REV, spd: LO, sig: HOME, edg: RISE};
    endfunction

    // reserved and unknown codes map to no program
    function automatic hsq_pkg::hsq_prog_type progOf(
        input logic [`HSQ_METHOD_W-1:0] m,
        input logic [3:0]               l
    );
        case (m)
            `HSQ_M11: progOf = l[HOME] ? hsq_pkg::P11A : hsq_pkg::P11N;
            `HSQ_M12: progOf = l[HOME] ? hsq_pkg::P12A : hsq_pkg::P12N;
            `HSQ_M13: progOf = hsq_pkg::P13N;
            `HSQ_M14: progOf = hsq_pkg::P14N;
            `HSQ_M17: progOf = l[RLIM] ? hsq_pkg::P17A : hsq_pkg::P17N;
            `HSQ_M18: progOf = l[FLIM] ? hsq_pkg::P18A : hsq_pkg::P18N;
            default:  progOf = hsq_pkg::PNONE;
        endcase
    endfunction

    function automatic hsq_pkg::hsq_prog_type limitOf(input hsq_pkg::hsq_prog_type p);
        case (p)
            hsq_pkg::P11N: limitOf = hsq_pkg::P11L;
            hsq_pkg::P12N: limitOf = hsq_pkg::P12L;
            hsq_pkg::P13N: limitOf = hsq_pkg::P13L;
            hsq_pkg::P14N: limitOf = hsq_pkg::P14L;
            default:       limitOf = hsq_pkg::PNONE;
        endcase
    endfunction

    function automatic hsq_pkg::hsq_step_type stepOf(
        input hsq_pkg::hsq_prog_type  p,
        input logic [`HSQ_STEP_W-1:0] i
    );
        hsq_pkg::hsq_step_type dec;
        dec = fixed(hsq_pkg::K_DECEL);
        case ({p, i})
            {hsq_pkg::P11N, 3'h0}: stepOf = srch(REV, HI, HOME, RISE);
            {hsq_pkg::P11N, 3'h1}: stepOf = dec;
            {hsq_pkg::P11N, 3'h2}: stepOf = srch(FWD, LO, HOME, FALL);
            {hsq_pkg::P11N, 3'h3}: stepOf = srch(FWD, LO, INDEX, RISE);
            {hsq_pkg::P11A, 3'h0}: stepOf = srch(FWD, LO, HOME, FALL);
            {hsq_pkg::P11A, 3'h1}: stepOf = srch(FWD, LO, INDEX, RISE);
            {hsq_pkg::P11L, 3'h0}: stepOf = srch(FWD, HI, HOME, FALL);
            {hsq_pkg::P11L, 3'h1}: stepOf = dec;
            {hsq_pkg::P11L, 3'h2}: stepOf = srch(REV, LO, HOME, RISE);
            {hsq_pkg::P11L, 3'h3}: stepOf = srch(FWD, LO, INDEX, RISE);
            {hsq_pkg::P12N, 3'h0}: stepOf = srch(REV, HI, HOME, RISE);
            {hsq_pkg::P12N, 3'h1}: stepOf = dec;
            {hsq_pkg::P12N, 3'h2}: stepOf = srch(FWD, LO, HOME, FALL);
            {hsq_pkg::P12N, 3'h3}: stepOf = srch(REV, LO, HOME, RISE);
            {hsq_pkg::P12N, 3'h4}: stepOf = srch(REV, LO, INDEX, RISE);
            {hsq_pkg::P12A, 3'h0}: stepOf = srch(FWD, LO, HOME, FALL);
            {hsq_pkg::P12A, 3'h1}: stepOf = srch(REV, LO, HOME, RISE);
            {hsq_pkg::P12A, 3'h2}: stepOf = srch(REV, LO, INDEX, RISE);
            {hsq_pkg::P12L, 3'h0}: stepOf = srch(FWD, HI, HOME, FALL);
            {hsq_pkg::P12L, 3'h1}: stepOf = dec;
            {hsq_pkg::P12L, 3'h2}: stepOf = srch(REV, LO, HOME, RISE);
            {hsq_pkg::P12L, 3'h3}: stepOf = srch(REV, LO, INDEX, RISE);
            {hsq_pkg::P13N, 3'h0}: stepOf = srch(REV, HI, HOME, FALL);
            {hsq_pkg::P13N, 3'h1}: stepOf = dec;
            {hsq_pkg::P13N, 3'h2}: stepOf = srch(FWD, LO, HOME, RISE);
            {hsq_pkg::P13N, 3'h3}: stepOf = srch(FWD, LO, INDEX, RISE);
            {hsq_pkg::P13L, 3'h0}: stepOf = srch(FWD, HI, HOME, RISE);
            {hsq_pkg::P13L, 3'h1}: stepOf = dec;
            {hsq_pkg::P13L, 3'h2}: stepOf = srch(REV, LO, HOME, FALL);
            {hsq_pkg::P13L, 3'h3}: stepOf = srch(FWD, LO, HOME, RISE);
            {hsq_pkg::P13L, 3'h4}: stepOf = srch(FWD, LO, INDEX, RISE);
            {hsq_pkg::P14N, 3'h0}: stepOf = srch(REV, HI, HOME, FALL);
            {hsq_pkg::P14N, 3'h1}: stepOf = dec;
            {hsq_pkg::P14N, 3'h2}: stepOf = srch(FWD, LO, HOME, RISE);
            {hsq_pkg::P14N, 3'h3}: stepOf = srch(REV, LO, HOME, FALL);
            {hsq_pkg::P14N, 3'h4}: stepOf = srch(REV, LO, INDEX, RISE);
            {hsq_pkg::P14L, 3'h0}: stepOf = srch(FWD, HI, HOME, RISE);
            {hsq_pkg::P14L, 3'h1}: stepOf = dec;
            {hsq_pkg::P14L, 3'h2}: stepOf = srch(REV, LO, HOME, FALL);
            {hsq_pkg::P14L, 3'h3}: stepOf = srch(REV, LO, INDEX, RISE);
            {hsq_pkg::P17N, 3'h0}: stepOf = srch(REV, HI, RLIM, RISE);
            {hsq_pkg::P17N, 3'h1}: stepOf = dec;
            {hsq_pkg::P17N, 3'h2}: stepOf = srch(FWD, LO, RLIM, FALL);
            {hsq_pkg::P17A, 3'h0}: stepOf = srch(FWD, LO, RLIM, FALL);
            {hsq_pkg::P18N, 3'h0}: stepOf = srch(FWD, HI, FLIM, RISE);
            {hsq_pkg::P18N, 3'h1}: stepOf = dec;
            {hsq_pkg::P18N, 3'h2}: stepOf = srch(REV, LO, FLIM, FALL);
            {hsq_pkg::P18A, 3'h0}: stepOf = srch(REV, LO, FLIM, FALL);
            default:               stepOf = fixed(hsq_pkg::K_END);
        endcase
    endfunction

    assign startTake = startHoming && (state_q != hsq_pkg::ST_RUN);
    assign curStep   = stepOf(prog_q, idx_q);
    assign hit       = (curStep.edg == RISE) ? rise[curStep.sig] : fall[curStep.sig];
    // only the first, fast reverse search of 11..14 falls back on the reverse limit
    assign fallback  = (idx_q == `HSQ_STEP_FIRST) && (limitOf(prog_q) != hsq_pkg::PNONE)
                       && rise[RLIM];

    always_comb
    begin
        state_d = state_q;
        prog_d  = prog_q;
        idx_d   = idx_q;
        cnt_d   = cnt_q;
        case (state_q)
            hsq_pkg::ST_RUN:
            begin
                case (curStep.kind)
                    hsq_pkg::K_SEARCH:
                    begin
                        // target edge wins over a limit edge in the same cycle
                        if (hit)
                        begin
                            idx_d = idx_q + `HSQ_STEP_INC;
                        end
                        else if (fallback)
                        begin
                            prog_d = limitOf(prog_q);
                            idx_d  = `HSQ_STEP_FIRST;
                        end
                    end
                    hsq_pkg::K_DECEL:
                    begin
                        if (cnt_q == DW'(DECEL_CYCLES - 1))
                        begin
                            cnt_d = '0;
                            idx_d = idx_q + `HSQ_STEP_INC;
                        end
                        else
                        begin
                            cnt_d = cnt_q + 1'b1;
                        end
                    end
                    default:
                    begin
                        state_d = hsq_pkg::ST_DONE;
                    end
                endcase
            end
            default:
            begin
                if (startTake)
                begin
                    prog_d  = progOf(methodSel, lvl);
                    idx_d   = `HSQ_STEP_FIRST;
                    cnt_d   = '0;
                    state_d = (prog_d == hsq_pkg::PNONE) ? hsq_pkg::ST_FAULT : hsq_pkg::ST_RUN;
                end
            end
        endcase
    end

    // outputs follow the next step so they line up with the state registers
    always_comb
    begin
        nxtStep    = stepOf(prog_d, idx_d);
        moveFwd_d  = (nxtStep.dir == FWD);
        speedCmd_d = '0;
        if ((state_d == hsq_pkg::ST_RUN) && (nxtStep.kind == hsq_pkg::K_SEARCH))
        begin
            speedCmd_d = (nxtStep.spd == HI) ? highSpeed : lowSpeed;
        end
    end

    always_ff @(posedge clk or negedge rstN_q)
    begin
        if (!rstN_q)
        begin
            state_q       <= hsq_pkg::ST_IDLE;
            prog_q        <= hsq_pkg::PNONE;
            idx_q         <= '0;
            cnt_q         <= '0;
            prevLvl_q     <= '0;
            moveFwd_q     <= 1'b0;
            speedCmd_q    <= '0;
            homingBusy_q  <= 1'b0;
            homingDone_q  <= 1'b0;
            methodError_q <= 1'b0;
        end
        else
        begin
            state_q       <= state_d;
            prog_q        <= prog_d;
            idx_q         <= idx_d;
            cnt_q         <= cnt_d;
            prevLvl_q     <= lvl;
            moveFwd_q     <= moveFwd_d;
            speedCmd_q    <= speedCmd_d;
            homingBusy_q  <= (state_d == hsq_pkg::ST_RUN);
            homingDone_q  <= (state_d == hsq_pkg::ST_DONE);
            methodError_q <= (state_d == hsq_pkg::ST_FAULT);
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstN_q);

    logic lastHit;
    logic inDecel;
    assign lastHit = (state_q == hsq_pkg::ST_RUN) && (curStep.kind == hsq_pkg::K_SEARCH) && hit
                     && (stepOf(prog_q, idx_q + `HSQ_STEP_INC).kind == hsq_pkg::K_END);
    assign inDecel = (state_q == hsq_pkg::ST_RUN) && (curStep.kind == hsq_pkg::K_DECEL);

    sequence s_take(logic [`HSQ_METHOD_W-1:0] m);
        startTake && (methodSel == m);
    endsequence

    sequence s_fastRev;
        !moveFwd_q && (speedCmd_q == $past(highSpeed)) && homingBusy_q;
    endsequence

    sequence s_slowFwd;
        moveFwd_q && (speedCmd_q == $past(lowSpeed)) && homingBusy_q;
    endsequence

    property p_m11Clear;
        s_take(`HSQ_M11) ##0 !lvl[HOME] |=> s_fastRev;
    endproperty
    a_m11Clear: assert property (p_m11Clear) else $error("m11 did not start fast reverse");

    property p_m11Active;
        s_take(`HSQ_M11) ##0 lvl[HOME] |=> s_slowFwd;
    endproperty
    a_m11Active: assert property (p_m11Active) else $error("m11 on switch not slow forward");

    property p_limitTurn;
        (state_q == hsq_pkg::ST_RUN) && fallback && !hit |=>
            moveFwd_q && (speedCmd_q == $past(highSpeed)) && (idx_q == `HSQ_STEP_FIRST);
    endproperty
    a_limitTurn: assert property (p_limitTurn) else $error("reverse limit did not turn to fast forward");

    property p_m12Active;
        s_take(`HSQ_M12) ##0 lvl[HOME] |=> s_slowFwd;
    endproperty
    a_m12Active: assert property (p_m12Active) else $error("m12 on switch not slow forward");

    property p_m13Any;
        s_take(`HSQ_M13) |=> s_fastRev;
    endproperty
    a_m13Any: assert property (p_m13Any) else $error("m13 did not start fast reverse");

    property p_m14Any;
        s_take(`HSQ_M14) |=> s_fastRev;
    endproperty
    a_m14Any: assert property (p_m14Any) else $error("m14 did not start fast reverse");

    property p_reserved;
        s_take(`HSQ_M15) or s_take(`HSQ_M16) |=>
            methodError_q && !homingBusy_q && (speedCmd_q == '0);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved method was not refused");

    property p_m17Start;
        s_take(`HSQ_M17) |=> (moveFwd_q == $past(lvl[RLIM]))
            && (speedCmd_q == ($past(lvl[RLIM]) ? $past(lowSpeed) : $past(highSpeed)));
    endproperty
    a_m17Start: assert property (p_m17Start) else $error("m17 start motion wrong");

    property p_m18Start;
        s_take(`HSQ_M18) |=> (moveFwd_q == !$past(lvl[FLIM]))
            && (speedCmd_q == ($past(lvl[FLIM]) ? $past(lowSpeed) : $past(highSpeed)));
    endproperty
    a_m18Start: assert property (p_m18Start) else $error("m18 start motion wrong");

    property p_decelStill;
        inDecel |-> (speedCmd_q == '0);
    endproperty
    a_decelStill: assert property (p_decelStill) else $error("speed not zero while decelerating");

    property p_finish;
        lastHit |-> ##2 homingDone_q && !homingBusy_q && (speedCmd_q == '0);
    endproperty
    a_finish: assert property (p_finish) else $error("done not raised two cycles after last edge");

endmodule

`default_nettype wire

// ===== hw/hsq_params.svh
/*
 * constants of the homing sequencer: clock rate, timings, method codes.
 * assumes a single 50 MHz clock; included by bare name.
 */
`ifndef HSQ_PARAMS_SVH
`define HSQ_PARAMS_SVH

`define HSQ_CLK_MHZ            50
`define HSQ_DECEL_TIME_US      20
`define HSQ_DECEL_CYC          (`HSQ_DECEL_TIME_US * `HSQ_CLK_MHZ)
`define HSQ_DEBOUNCE_TIME_US   50
`define HSQ_DEBOUNCE_CYC       (`HSQ_DEBOUNCE_TIME_US * `HSQ_CLK_MHZ)
`define HSQ_INDEX_FILT_CYC     2
`define HSQ_SPEED_W            16
`define HSQ_METHOD_W           8
`define HSQ_STEP_W             3
`define HSQ_STEP_FIRST         3'h0
`define HSQ_STEP_INC           3'h1

`define HSQ_M11                8'h0B
`define HSQ_M12                8'h0C
`define HSQ_M13                8'h0D
`define HSQ_M14                8'h0E
`define HSQ_M15                8'h0F
`define HSQ_M16                8'h10
`define HSQ_M17                8'h11
`define HSQ_M18                8'h12

`endif

// ===== hw/hsq_pkg.sv
/*
 * types of the homing sequencer: states, step table entries, programs.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package hsq_pkg;

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE, ST_FAULT} hsq_state_type;
    typedef enum logic [1:0] {K_SEARCH, K_DECEL, K_END} hsq_kind_type;
    typedef enum logic {DIR_REV, DIR_FWD} hsq_dir_type;
    typedef enum logic {SPD_LOW, SPD_HIGH} hsq_spd_type;
    typedef enum logic [1:0] {SIG_HOME, SIG_REVLIM, SIG_FWDLIM, SIG_INDEX} hsq_sig_type;
    typedef enum logic {EDGE_FALL, EDGE_RISE} hsq_edge_type;
    typedef enum logic [3:0] {P11N, P11A, P11L, P12N, P12A, P12L, P13N, P13L,
                              P14N, P14L, P17N, P17A, P18N, P18A, PNONE} hsq_prog_type;

    typedef struct packed {
        hsq_kind_type kind;
        hsq_dir_type  dir;
        hsq_spd_type  spd;
        hsq_sig_type  sig;
        hsq_edge_type edg;
    } hsq_step_type;

endpackage

// ===== hw/hsq_debounce.sv
/*
 * two-flop synchroniser and counting filter per input bit.
 * assumes inputs synchronous or slow; level changes only after CYCLES steady samples.
 */
`timescale 1ns/100ps
`default_nettype none
`include "hsq_params.svh"

module hsq_debounce #(
    parameter int WIDTH  = 1,
    parameter int CYCLES = `HSQ_DEBOUNCE_CYC
) (
    input  wire logic             clk,
    input  wire logic             rstN,
    input  wire logic [WIDTH-1:0] raw,
    output logic      [WIDTH-1:0] level
);

    localparam int CW = $clog2(CYCLES + 1);

    for (genvar b = 0; b < WIDTH; b++)
    begin : g_bit
        logic          meta_q;
        logic          sync_q;
        logic          lvl_q;
        logic          lvl_d;
        logic [CW-1:0] cnt_q;
        logic [CW-1:0] cnt_d;

        always_comb
        begin
            lvl_d = lvl_q;
            cnt_d = cnt_q;
            if (sync_q == lvl_q)
            begin
                cnt_d = '0;
            end
            else if (cnt_q == CW'(CYCLES - 1))
            begin
                lvl_d = sync_q;
                cnt_d = '0;
            end
            else
            begin
                cnt_d = cnt_q + 1'b1;
            end
        end

        always_ff @(posedge clk or negedge rstN)
        begin
            if (!rstN)
            begin
                meta_q <= 1'b0;
                sync_q <= 1'b0;
                lvl_q  <= 1'b0;
                cnt_q  <= '0;
            end
            else
            begin
                meta_q <= raw[b];
                sync_q <= meta_q;
                lvl_q  <= lvl_d;
                cnt_q  <= cnt_d;
            end
        end

        assign level[b] = lvl_q;
    end

endmodule

`default_nettype wire

// ===== tb/hsq_motor_model.sv
/*
 * axis model: motor position, home switch, limits, encoder index.
 * assumes one count of travel per clock while speed is nonzero.
 */
`timescale 1ns/100ps
`default_nettype none

module hsq_motor_model #(
    parameter int HOME_LO = 400,
    parameter int HOME_HI = 499,
    parameter int REV_POS = 100,
    parameter int FWD_POS = 900
) (
    input  wire logic        clk,
    input  wire logic        moveFwd,
    input  wire logic [15:0] speedCmd,
    input  wire logic        loadPos,
    input  wire logic [15:0] loadVal,
    output logic      [15:0] pos,
    output logic             homeSwitch,
    output logic             fwdLimit,
    output logic             revLimit,
    output logic             indexPulse
);
    // moves on the falling edge, like all bench stimulus
    always @(negedge clk)
    begin
        if (loadPos)
            pos <= loadVal;
        else if (speedCmd != 16'h0000)
            pos <= moveFwd ? pos + 16'h0001 : pos - 16'h0001;
    end
    assign homeSwitch = (pos >= HOME_LO) && (pos <= HOME_HI);
    assign revLimit   = pos <= REV_POS;
    assign fwdLimit   = pos >= FWD_POS;
    // index four counts wide every 32, long enough for the filter
    assign indexPulse = pos[4:2] == 3'h0;
endmodule

`default_nettype wire

// ===== tb/hsq_homing_bench.sv
/*
 * bench of the homing sequencer: start positions per method, end windows.
 * assumes the motor model; debounce and decel shortened.
 */
`timescale 1ns/100ps
`default_nettype none
`include "hsq_params.svh"
`define CHK(what, exp, got) \
    begin checks++; if ((got) !== (exp)) begin failures++; \
    $display("BAD %s expected %0h seen %0h", what, exp, got); end end

module hsq_homing_bench;
    logic        clk, nrst, startHoming, loadPos, moveFwd, busy, done, methodError;
    logic        homeSwitch, fwdLimit, revLimit, indexPulse;
    logic [7:0]  methodSel;
    logic [15:0] highSpeed, lowSpeed, loadVal, pos, speedCmd;
    int          failures, checks, cycles;

    hsq_homing #(.DECEL_CYCLES(4), .DEBOUNCE_CYCLES(3)) hsq_homing_i (
        .clk(clk), .nrst(nrst), .startHoming(startHoming), .methodSel(methodSel),
        .highSpeed(highSpeed), .lowSpeed(lowSpeed), .homeSwitch(homeSwitch),
        .fwdLimit(fwdLimit), .revLimit(revLimit), .indexPulse(indexPulse),
        .moveFwd_q(moveFwd), .speedCmd_q(speedCmd), .homingBusy_q(busy),
        .homingDone_q(done), .methodError_q(methodError));
    hsq_motor_model hsq_motor_model_i (
        .clk(clk), .moveFwd(moveFwd), .speedCmd(speedCmd), .loadPos(loadPos),
        .loadVal(loadVal), .pos(pos), .homeSwitch(homeSwitch), .fwdLimit(fwdLimit),
        .revLimit(revLimit), .indexPulse(indexPulse));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic stop_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // about 4.5k cycles expected
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            failures++;
            stop_test();
        end
    end

    task automatic kick(input logic [7:0] m);
        methodSel = m;
        startHoming = 1'b1;
        @(negedge clk);
        startHoming = 1'b0;
        @(negedge clk);
    endtask

    // place the axis, start, check first move, wait for done, check end window
    task automatic run(input logic [7:0] m, input logic [15:0] p, input logic fwd,
                       input logic fast, input logic [15:0] lo, input logic [15:0] hi);
        int n;
        n = 0;
        loadVal = p;
        loadPos = 1'b1;
        // held over a whole falling edge: the model samples on that edge too
        repeat (2) @(negedge clk);
        loadPos = 1'b0;
        repeat (20) @(negedge clk);
        kick(m);
        `CHK("direction", fwd, moveFwd)
        `CHK("speed", fast ? highSpeed : lowSpeed, speedCmd)
        while (done !== 1'b1 && n < 3000)
        begin
            @(negedge clk);
            n++;
        end
        `CHK("done", 1'b1, done)
        `CHK("stopped", {busy, speedCmd}, 17'h0_0000)
        `CHK("end position", 1'b1, pos >= lo && pos <= hi)
        $display("test method %0d ends", m);
    endtask

    task automatic switchTests;
        run(`HSQ_M11, 16'h02BC, 1'b0, 1'b1, 16'h01F9, 16'h0212);
        run(`HSQ_M11, 16'h01C2, 1'b1, 1'b0, 16'h01F9, 16'h0212);
        run(`HSQ_M11, 16'h012C, 1'b0, 1'b1, 16'h01F9, 16'h0212);
        run(`HSQ_M12, 16'h02BC, 1'b0, 1'b1, 16'h01CC, 16'h01EA);
        run(`HSQ_M12, 16'h01C2, 1'b1, 1'b0, 16'h01CC, 16'h01EA);
        run(`HSQ_M12, 16'h012C, 1'b0, 1'b1, 16'h01CC, 16'h01EA);
    endtask

    task automatic fallEdgeTests;
        run(`HSQ_M13, 16'h02BC, 1'b0, 1'b1, 16'h019A, 16'h01AE);
        run(`HSQ_M13, 16'h01C2, 1'b0, 1'b1, 16'h019A, 16'h01AE);
        run(`HSQ_M13, 16'h012C, 1'b0, 1'b1, 16'h019A, 16'h01AE);
        run(`HSQ_M14, 16'h01C2, 1'b0, 1'b1, 16'h0172, 16'h0186);
        run(`HSQ_M14, 16'h012C, 1'b0, 1'b1, 16'h0172, 16'h0186);
    endtask

    task automatic limitTests;
        run(`HSQ_M17, 16'h012C, 1'b0, 1'b1, 16'h0064, 16'h0073);
        run(`HSQ_M17, 16'h0032, 1'b1, 1'b0, 16'h0064, 16'h0073);
        run(`HSQ_M18, 16'h02BC, 1'b1, 1'b1, 16'h0375, 16'h0384);
        run(`HSQ_M18, 16'h03B6, 1'b0, 1'b0, 16'h0375, 16'h0384);
    endtask

    // refused codes straight after a finished run
    task automatic reservedTests;
        kick(`HSQ_M15);
        `CHK("refused 15", {methodError, busy, done, speedCmd}, 19'h4_0000)
        kick(`HSQ_M16);
        `CHK("refused 16", {methodError, busy, done, speedCmd}, 19'h4_0000)
        $display("test reserved ends");
    endtask

    initial
    begin
        nrst = 1'b0;
        startHoming = 1'b0;
        methodSel = 8'h00;
        highSpeed = 16'h0200;
        lowSpeed = 16'h0020;
        loadPos = 1'b1;
        loadVal = 16'h02BC;
        failures = 0;
        checks = 0;
        cycles = 0;
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        repeat (10) @(negedge clk);
        switchTests();
        fallEdgeTests();
        limitTests();
        reservedTests();
        stop_test();
    end
endmodule

`default_nettype wire
